// ### core/uil_irq_logic.sv
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
module uil_irq_logic
	import uil_pkg::*;
#(
	parameter int IDLE_CNT  = IDLE_CYCLES,
	parameter int WAKE_SYNC = WAKE_SYNC_CYCLES
) (
	input  wire logic       mclk_i,
	input  wire logic       nrst_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       sof_evt_i,
	input  wire logic       stall_evt_i,
	input  wire logic       trn_done_evt_i,
	input  wire logic       bus_reset_evt_i,
	input  wire logic       bus_active_i,
	input  wire logic       stuff_err_i,
	input  wire logic       turn_timeout_i,
	input  wire logic       field_size_err_i,
	input  wire logic       data_crc_err_i,
	input  wire logic       token_crc_err_i,
	input  wire logic       pid_err_i,
	output logic            module_irq_request_o,
	output logic            suspend_ctrl_bit_o
);
	localparam int ICW = $clog2(IDLE_CNT + 1);

	logic          rst_meta_q;
	logic          rst_n_q;
	logic [7:0]    status_irq_enable_q;
	logic [7:0]    status_irq_flags_q;
	logic [7:0]    error_flag_status_q;
	logic [7:0]    error_irq_enable_q;
	logic          bus_active_s;
	logic [ICW-1:0] idle_cnt_q;
	logic          idle_hit;
	uil_act_e      act_state_q;
	logic          act_raise;
	logic          act_block;
	logic          error_summary_flag;
	logic [7:0]    err_set;
	logic [7:0]    stat_set;
	logic [7:0]    stat_view;
	logic          wr_stat;
	logic          wr_err;

	always_ff @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	// bus activity arrives from the line domain
	uil_sync2 #(.W(1)) u_act_sync (
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_q),
		.d_i     (bus_active_i),
		.q_o     (bus_active_s)
	);

	uil_wake_window #(.CYCLES(WAKE_SYNC)) u_wake (
		.mclk_i    (mclk_i),
		.rst_n_i   (rst_n_q),
		.suspend_i (suspend_ctrl_bit_o),
		.block_o   (act_block)
	);

	assign wr_stat = wr_i && (addr_i == ADDR_STATUS_FLAGS);
	assign wr_err  = wr_i && (addr_i == ADDR_ERROR_FLAGS);

	// idle timer: counts quiet cycles, fires once per idle period
	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			idle_cnt_q <= '0;
		end else if (bus_active_s) begin
			idle_cnt_q <= '0;
		end else if (idle_cnt_q != ICW'(IDLE_CNT)) begin
			idle_cnt_q <= idle_cnt_q + ICW'(1);
		end
	end
	assign idle_hit = !bus_active_s && (idle_cnt_q == ICW'(IDLE_CNT - 1));

	// activity event arms only after an idle period
	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			act_state_q <= UIL_ACT_WAIT_IDLE;
		end else begin
			case (act_state_q)
				UIL_ACT_ARMED: begin
					if (bus_active_s) begin
						act_state_q <= UIL_ACT_RAISED;
					end
				end
				UIL_ACT_RAISED: begin
					if (idle_hit) begin
						act_state_q <= UIL_ACT_ARMED;
					end else if (!status_irq_flags_q[BIT_BUS_ACT]) begin
						act_state_q <= UIL_ACT_WAIT_IDLE;
					end
				end
				default: begin
					if (idle_hit) begin
						act_state_q <= UIL_ACT_ARMED;
					end
				end
			endcase
		end
	end
	assign act_raise = (act_state_q == UIL_ACT_ARMED) && bus_active_s;

	always_comb begin
		stat_set = 8'h00;
		stat_set[BIT_SOF]       = sof_evt_i;
		stat_set[BIT_STALL]     = stall_evt_i;
		stat_set[BIT_IDLE]      = idle_hit;
		stat_set[BIT_TRN_DONE]  = trn_done_evt_i;
		stat_set[BIT_BUS_ACT]   = act_raise;
		stat_set[BIT_BUS_RESET] = bus_reset_evt_i;
	end

	// status flags: set wins over a firmware write; firmware may also set for debug
	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_irq_flags_q <= RESET_BYTE;
		end else begin
			for (int i = 0; i < 8; i++) begin
				if (stat_set[i]) begin
					status_irq_flags_q[i] <= 1'b1;
				end else if (wr_stat && STATUS_MASK[i] && i != BIT_ERR_SUMMARY) begin
					if (i == BIT_BUS_ACT && act_block && !wdata_i[i]) begin
						status_irq_flags_q[i] <= status_irq_flags_q[i];
					end else begin
						status_irq_flags_q[i] <= wdata_i[i];
					end
				end
			end
			status_irq_flags_q[BIT_ERR_SUMMARY] <= 1'b0;
			status_irq_flags_q[7] <= 1'b0;
		end
	end

	always_comb begin
		err_set = 8'h00;
		err_set[EBIT_STUFF] = stuff_err_i;
		err_set[EBIT_TURN]  = turn_timeout_i;
		err_set[EBIT_FIELD] = field_size_err_i;
		err_set[EBIT_CRC16] = data_crc_err_i;
		err_set[EBIT_CRC5]  = token_crc_err_i;
		err_set[EBIT_PID]   = pid_err_i;
	end

	// error flags: set immediately, cleared only by writing zero
	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			error_flag_status_q <= RESET_BYTE;
		end else if (wr_err) begin
			error_flag_status_q <= (err_set | (error_flag_status_q & wdata_i)) & ERROR_MASK;
		end else begin
			error_flag_status_q <= (err_set | error_flag_status_q) & ERROR_MASK;
		end
	end

	assign error_summary_flag = |(error_flag_status_q & error_irq_enable_q);

	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_irq_enable_q <= RESET_BYTE;
			error_irq_enable_q  <= RESET_BYTE;
			suspend_ctrl_bit_o  <= 1'b0;
		end else if (wr_i) begin
			if (addr_i == ADDR_STATUS_ENABLE) begin
				status_irq_enable_q <= wdata_i & STATUS_MASK;
			end else if (addr_i == ADDR_ERROR_ENABLE) begin
				error_irq_enable_q <= wdata_i & ERROR_MASK;
			end else if (addr_i == ADDR_CONTROL) begin
				suspend_ctrl_bit_o <= wdata_i[CBIT_SUSPEND];
			end
		end
	end

	always_comb begin
		stat_view = status_irq_flags_q;
		stat_view[BIT_ERR_SUMMARY] = error_summary_flag;
	end

	// request is registered so the output comes straight from a flop
	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			module_irq_request_o <= 1'b0;
		end else begin
			module_irq_request_o <= |(stat_view & status_irq_enable_q);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			if (addr_i == ADDR_STATUS_FLAGS) begin
				rdata_o <= stat_view;
			end else if (addr_i == ADDR_STATUS_ENABLE) begin
				rdata_o <= status_irq_enable_q;
			end else if (addr_i == ADDR_ERROR_FLAGS) begin
				rdata_o <= error_flag_status_q;
			end else if (addr_i == ADDR_ERROR_ENABLE) begin
				rdata_o <= error_irq_enable_q;
			end else if (addr_i == ADDR_CONTROL) begin
				rdata_o <= {7'h00, suspend_ctrl_bit_o};
			end else begin
				rdata_o <= 8'h00;
			end
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// every event must land even when a firmware write hits the same cycle
	a_err_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		$past(error_flag_status_q[EBIT_PID]) && !$past(wr_err) |-> error_flag_status_q[EBIT_PID])
		else $error("error flag dropped without write");
	a_err_clear_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		wr_err && !wdata_i[EBIT_PID] && !pid_err_i |=> !error_flag_status_q[EBIT_PID])
		else $error("error flag not cleared by zero write");
	a_err_set_now: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		data_crc_err_i |=> error_flag_status_q[EBIT_CRC16])
		else $error("error flag not set at detection");
	a_err_set_pid: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		pid_err_i |=> error_flag_status_q[EBIT_PID])
		else $error("packet id error flag not set");
	a_err_set_token: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		token_crc_err_i |=> error_flag_status_q[EBIT_CRC5])
		else $error("token crc error flag not set");
	a_err_set_field: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		field_size_err_i |=> error_flag_status_q[EBIT_FIELD])
		else $error("field size error flag not set");
	a_err_set_turn: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		turn_timeout_i |=> error_flag_status_q[EBIT_TURN])
		else $error("turnaround error flag not set");
	a_err_set_stuff: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		stuff_err_i |=> error_flag_status_q[EBIT_STUFF])
		else $error("stuffing error flag not set");
	a_err_unimpl_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		error_flag_status_q[6:5] == 2'b00)
		else $error("unimplemented error bits set");
	a_err_en_gap: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		error_irq_enable_q[6:5] == 2'b00)
		else $error("unimplemented error enable bits set");
	a_read_err_gap: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		$past(rd_i) && $past(addr_i) == ADDR_ERROR_FLAGS |-> rdata_o[6:5] == 2'b00)
		else $error("unimplemented error bits read back");
	a_act_clear_blocked: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		wr_stat && act_block && status_irq_flags_q[BIT_BUS_ACT] |=> status_irq_flags_q[BIT_BUS_ACT])
		else $error("activity flag cleared while blocked");
	a_act_clear_free: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		wr_stat && !act_block && !wdata_i[BIT_BUS_ACT] && !act_raise
		|=> !status_irq_flags_q[BIT_BUS_ACT])
		else $error("activity flag clear lost after sync");
	a_act_block_susp: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		suspend_ctrl_bit_o |-> act_block)
		else $error("activity clear open while suspended");
	a_act_block_wake: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		$fell(suspend_ctrl_bit_o) |-> act_block)
		else $error("activity clear open right after wake");
	a_act_once: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		act_state_q == UIL_ACT_WAIT_IDLE && !idle_hit |=> !act_raise)
		else $error("activity raised without idle");
	a_act_raise_once: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		act_raise |=> !act_raise)
		else $error("activity raised twice in a row");
	a_idle_set: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		idle_hit |=> status_irq_flags_q[BIT_IDLE])
		else $error("idle flag not set after idle period");
	a_idle_once: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		idle_hit |=> !idle_hit)
		else $error("idle detected twice in one period");
	a_irq_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		status_irq_enable_q == 8'h00 |=> !module_irq_request_o)
		else $error("request with all enables off");
	a_irq_sof: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		status_irq_flags_q[BIT_SOF] && status_irq_enable_q[BIT_SOF] |=> module_irq_request_o)
		else $error("enabled frame flag gave no request");
	a_irq_summary: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		error_summary_flag && status_irq_enable_q[BIT_ERR_SUMMARY] |=> module_irq_request_o)
		else $error("enabled error summary gave no request");
	a_summary_or: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		stat_view[BIT_ERR_SUMMARY] == (
			(error_flag_status_q[EBIT_PID] && error_irq_enable_q[EBIT_PID]) ||
			(error_flag_status_q[EBIT_CRC5] && error_irq_enable_q[EBIT_CRC5]) ||
			(error_flag_status_q[EBIT_CRC16] && error_irq_enable_q[EBIT_CRC16]) ||
			(error_flag_status_q[EBIT_FIELD] && error_irq_enable_q[EBIT_FIELD]) ||
			(error_flag_status_q[EBIT_TURN] && error_irq_enable_q[EBIT_TURN]) ||
			(error_flag_status_q[EBIT_STUFF] && error_irq_enable_q[EBIT_STUFF])))
		else $error("summary mismatch");
	a_summary_ro: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		status_irq_flags_q[BIT_ERR_SUMMARY] == 1'b0)
		else $error("summary bit held a written value");
	a_read_summary: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		$past(rd_i) && $past(addr_i) == ADDR_STATUS_FLAGS
		|-> rdata_o[BIT_ERR_SUMMARY] == $past(error_summary_flag))
		else $error("summary read back wrong");
	a_stat_top_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		status_irq_flags_q[7] == 1'b0 && status_irq_enable_q[7] == 1'b0)
		else $error("unimplemented status bit set");
	a_read_top_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		$past(rd_i) && $past(addr_i) == ADDR_STATUS_FLAGS |-> !rdata_o[7])
		else $error("unimplemented status bit read back");
	a_flag_poll: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		sof_evt_i |=> status_irq_flags_q[BIT_SOF])
		else $error("flag not set while disabled");
	a_stat_set_stall: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		stall_evt_i |=> status_irq_flags_q[BIT_STALL])
		else $error("stall flag not set");
	a_stat_set_trn: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		trn_done_evt_i |=> status_irq_flags_q[BIT_TRN_DONE])
		else $error("transaction flag not set");
	a_stat_set_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_q)
		bus_reset_evt_i |=> status_irq_flags_q[BIT_BUS_RESET])
		else $error("bus reset flag not set");
endmodule

// ### common/uil_pkg.sv
package uil_pkg;

	// register addresses on the plain register port
	localparam logic [3:0] ADDR_STATUS_FLAGS  = 4'h0;
	localparam logic [3:0] ADDR_STATUS_ENABLE = 4'h1;
	localparam logic [3:0] ADDR_ERROR_FLAGS   = 4'h2;
	localparam logic [3:0] ADDR_ERROR_ENABLE  = 4'h3;
	localparam logic [3:0] ADDR_CONTROL       = 4'h4;

	// status flag / enable bit positions
	localparam int BIT_BUS_RESET   = 0;
	localparam int BIT_ERR_SUMMARY = 1;
	localparam int BIT_BUS_ACT     = 2;
	localparam int BIT_TRN_DONE    = 3;
	localparam int BIT_IDLE        = 4;
	localparam int BIT_STALL       = 5;
	localparam int BIT_SOF         = 6;

	// error flag bit positions
	localparam int EBIT_PID    = 0;
	localparam int EBIT_CRC5   = 1;
	localparam int EBIT_CRC16  = 2;
	localparam int EBIT_FIELD  = 3;
	localparam int EBIT_TURN   = 4;
	localparam int EBIT_STUFF  = 7;

	// control register bit position
	localparam int CBIT_SUSPEND = 0;

	// implemented bit masks; other bits read as zero
	localparam logic [7:0] STATUS_MASK = 8'h7f;
	localparam logic [7:0] ERROR_MASK  = 8'h9f;

	// values after reset
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// timing
	localparam int CLK_FREQ_HZ       = 250_000_000;
	localparam int IDLE_TIME_US      = 3000;
	localparam int IDLE_CYCLES       = (CLK_FREQ_HZ / 1_000_000) * IDLE_TIME_US;
	localparam int WAKE_SYNC_CYCLES  = 4;

	typedef enum logic [1:0] {
		UIL_ACT_ARMED,
		UIL_ACT_RAISED,
		UIL_ACT_WAIT_IDLE
	} uil_act_e;

endpackage

// ### core/uil_sync2.sv
`timescale 1ns/1ps
module uil_sync2 #(
	parameter int W = 1
) (
	input  wire logic         mclk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule

// ### core/uil_wake_window.sv
`timescale 1ns/1ps
module uil_wake_window #(
	parameter int CYCLES = 4
) (
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic suspend_i,
	output logic      block_o
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_q;

	// clears refused while suspended and until the counter runs out after wake
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
		end else if (suspend_i) begin
			cnt_q <= CW'(CYCLES);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - CW'(1);
		end
	end

	assign block_o = suspend_i || (cnt_q != '0);
endmodule

// ### bench/uil_fw_model.sv
`timescale 1ns/1ps
module uil_fw_model
	import uil_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic [7:0] rdata_i,
	output logic      [3:0] addr_o,
	output logic      [7:0] wdata_o,
	output logic            wr_o,
	output logic            rd_o
);
	initial begin
		addr_o = 4'h0;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge mclk_i);
		wr_o    <= 1'b0;
		// released data must not keep showing the last value
		wdata_o <= ~d;
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge mclk_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		#1 v = rdata_i;
	endtask

	// clears are refused during the wake sync window after suspend, so one clear may not be enough
	task automatic act_clear(output int tries);
		logic [7:0] v;
		tries = 0;
		do begin
			wr(ADDR_STATUS_FLAGS, 8'h00);
			rd(ADDR_STATUS_FLAGS, v);
			tries++;
		end while (v[BIT_BUS_ACT] && tries < 16);
	endtask
endmodule

// ### bench/uil_irq_logic_tb_top.sv
`timescale 1ns/1ps
module uil_irq_logic_tb_top;
	import uil_pkg::*;
	logic       mclk_i, nrst_i, bus_active_i, rd_seen, wr, rd, irq, susp;
	logic [3:0] addr, sevt;
	logic [5:0] eevt;
	logic [7:0] wdata, rdata, v, m, r;
	int         error_cnt, num_checks, seed, n;
	int         epos[6] = '{0, 1, 2, 3, 4, 7};
	int         spos[4] = '{0, 3, 5, 6};
	logic [7:0] exp_q[$];

	uil_irq_logic #(.IDLE_CNT(20), .WAKE_SYNC(4)) uil_irq_logic_i (
		.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sof_evt_i(sevt[3]),
		.stall_evt_i(sevt[2]), .trn_done_evt_i(sevt[1]), .bus_reset_evt_i(sevt[0]),
		.bus_active_i(bus_active_i), .stuff_err_i(eevt[5]), .turn_timeout_i(eevt[4]),
		.field_size_err_i(eevt[3]), .data_crc_err_i(eevt[2]),
		.token_crc_err_i(eevt[1]), .pid_err_i(eevt[0]),
		.module_irq_request_o(irq), .suspend_ctrl_bit_o(susp));

	uil_fw_model uil_fw_model_i (.mclk_i(mclk_i), .rdata_i(rdata), .addr_o(addr),
		.wdata_o(wdata), .wr_o(wr), .rd_o(rd));

	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		uil_fw_model_i.rd(a, v);
	endtask

	task automatic w(input logic [3:0] a, input logic [7:0] d);
		uil_fw_model_i.wr(a, d);
	endtask

	task automatic pulse(input bit err, input int k);
		@(posedge mclk_i);
		if (err) eevt <= 6'h01 << k;
		else sevt <= 4'h1 << k;
		@(posedge mclk_i);
		eevt <= 6'h00;
		sevt <= 4'h0;
	endtask

	task automatic irq_chk(input logic e);
		repeat (2) @(posedge mclk_i);
		#1 chk({7'h00, irq}, {7'h00, e});
	endtask

	task automatic bus(input logic l, input int k);
		@(posedge mclk_i);
		bus_active_i <= l;
		repeat (k) @(posedge mclk_i);
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge mclk_i) begin
		if (rd_seen && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
		rd_seen <= rd;
	end

	initial begin
		repeat (4000) @(posedge mclk_i);
		error_cnt++;
		tally_and_finish;
	end

	initial begin
		seed = 85997;
		nrst_i = 1'b0;
		bus_active_i = 1'b1;
		sevt = 4'h0;
		eevt = 6'h00;
		rd_seen = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		repeat (5) @(posedge mclk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		for (int a = 0; a < 6; a++) rd_chk((a == 5) ? 4'hf : 4'(a), 8'h00);
		r = 8'($random(seed));
		w(ADDR_STATUS_ENABLE, r);
		rd_chk(ADDR_STATUS_ENABLE, r & STATUS_MASK);
		w(ADDR_STATUS_FLAGS, 8'h02);
		rd_chk(ADDR_STATUS_FLAGS, 8'h00);
		for (int i = 0; i < 6; i++) begin
			m = 8'h01 << epos[i];
			w(ADDR_ERROR_ENABLE, i[0] ? m : 8'h00);
			w(ADDR_STATUS_ENABLE, 8'h02);
			pulse(1'b1, i);
			irq_chk(i[0]);
			rd_chk(ADDR_ERROR_FLAGS, m);
			rd_chk(ADDR_STATUS_FLAGS, i[0] ? 8'h02 : 8'h00);
			w(ADDR_ERROR_FLAGS, 8'hff);
			rd_chk(ADDR_ERROR_FLAGS, m);
			w(ADDR_ERROR_FLAGS, 8'h00);
			rd_chk(ADDR_ERROR_FLAGS, 8'h00);
		end
		for (int j = 0; j < 4; j++) begin
			m = 8'h01 << spos[j];
			w(ADDR_STATUS_ENABLE, 8'h00);
			pulse(1'b0, j);
			rd_chk(ADDR_STATUS_FLAGS, m);
			irq_chk(1'b0);
			w(ADDR_STATUS_ENABLE, m);
			irq_chk(1'b1);
			w(ADDR_STATUS_FLAGS, 8'h00);
			irq_chk(1'b0);
		end
		bus(1'b0, 40);
		bus(1'b1, 6);
		rd_chk(ADDR_STATUS_FLAGS, 8'h14);
		w(ADDR_STATUS_FLAGS, 8'h00);
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, 5);
			bus(1'b1, 5);
		end
		rd_chk(ADDR_STATUS_FLAGS, 8'h00);
		bus(1'b0, 40);
		bus(1'b1, 6);
		w(ADDR_CONTROL, 8'h01);
		irq_chk(1'b0);
		chk({7'h00, susp}, 8'h01);
		w(ADDR_STATUS_FLAGS, 8'h00);
		rd_chk(ADDR_STATUS_FLAGS, 8'h04);
		w(ADDR_CONTROL, 8'h00);
		w(ADDR_STATUS_FLAGS, 8'h00);
		rd_chk(ADDR_STATUS_FLAGS, 8'h04);
		uil_fw_model_i.act_clear(n);
		rd_chk(ADDR_STATUS_FLAGS, 8'h00);
		// clear right after wake: the first try falls inside the sync window
		bus(1'b0, 40);
		bus(1'b1, 6);
		w(ADDR_CONTROL, 8'h01);
		w(ADDR_CONTROL, 8'h00);
		uil_fw_model_i.act_clear(n);
		chk(8'(n), 8'h02);
		rd_chk(ADDR_STATUS_FLAGS, 8'h00);
		// let the monitor take the last read before the verdict
		repeat (2) @(posedge mclk_i);
		tally_and_finish;
	end
endmodule
